// [rtl/flash_ctl_regs.svh]
`ifndef FLASH_CTL_REGS_SVH
`define FLASH_CTL_REGS_SVH
`define SFR_ERASE_COMMAND      8'h94
`define SFR_FLASH_CONTROL      8'hb2
`define SFR_ERASE_PAGE_ADDRESS 8'hb7
`define ERASE_PATTERN_MASS     8'haa
`define ERASE_PATTERN_PAGE     8'h55
`define CTRL_PWE_BIT           0
`define CTRL_MEEN_BIT          1
`define CTRL_SECURE_BIT        6
`define CTRL_PREBOOT_BIT       7
`define RESET_VECTOR           16'h0000
`define VECTOR_BASE            16'h0003
`define VECTOR_SPACING         16'h0008
`define ERASE_PAGE_TIME        16'h0010
`define ERASE_MASS_TIME        16'h0020
`define WRITE_BYTE_TIME        16'h0004
`endif

// [rtl/flash_ctl_pkg.sv]
package flash_ctl_pkg;
  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_page  = 2'b01,
    st_mass  = 2'b10,
    st_write = 2'b11
  } op_state_e;

  typedef struct packed {
    logic       we;
    logic       re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [7:0]  data;
  } mem_wr_s;
endpackage : flash_ctl_pkg

// [rtl/flash_erase_write_control.sv]
`timescale 1ns/1ns
`default_nettype none
`include "flash_ctl_regs.svh"
module flash_erase_write_control (
  input  wire logic                  clk_i,
  input  wire logic                  resetn_i,
  input  wire flash_ctl_pkg::sfr_req_s sfr_i,
  output logic [7:0]                 sfr_rdata_o,
  input  wire logic                  ice_enabled_i,
  input  wire logic                  preboot_i,
  input  wire logic                  irq_enabled_i,
  input  wire logic                  store_dptr_i,
  input  wire logic                  store_ri_i,
  input  wire logic [15:0]           store_addr_i,
  input  wire logic [7:0]            store_acc_i,
  input  wire logic                  fetch_i,
  input  wire logic                  table_read_i,
  input  wire logic [15:0]           code_addr_i,
  input  wire logic                  ext_read_i,
  input  wire logic [2:0]            vector_index_i,
  output flash_ctl_pkg::mem_wr_s     flash_wr_o,
  output flash_ctl_pkg::mem_wr_s     xram_wr_o,
  output logic                       code_rd_o,
  output logic [15:0]                code_rd_addr_o,
  output logic                       page_erase_o,
  output logic                       mass_erase_o,
  output logic [6:0]                 erase_page_o,
  output logic                       busy_o,
  output logic                       ext_read_block_o,
  output logic [15:0]                vector_addr_o
);
  // the external reset pin is active high; the block sees it inverted on resetn_i
  // ==========================================================
  // sfr state
  logic                     pwe, next_pwe;
  logic                     meen, next_meen;
  logic                     secure, next_secure;
  logic                     pre_s1, pre_s2, ice_s1, ice_s2;
  logic [7:0]               pgadr, next_pgadr;
  logic                     pg_fresh, next_pg_fresh;
  logic [7:0]               rdata, next_rdata;
  flash_ctl_pkg::op_state_e state, next_state;
  logic [15:0]              cnt, next_cnt;
  flash_ctl_pkg::mem_wr_s   fwr, next_fwr, xwr, next_xwr;
  logic                     pe, next_pe, me, next_me;
  logic                     crd, next_crd;
  logic [15:0]              crd_addr, next_crd_addr;
  logic [15:0]              vec, next_vec;
  // busy is registered so the output never carries a decode glitch
  logic                     bsy, next_bsy;
  logic [5:0]               run_len, next_run_len;
  logic                     wr_ctrl, wr_erase, wr_pg, idle;

  assign wr_ctrl  = sfr_i.we && sfr_i.addr == `SFR_FLASH_CONTROL;
  assign wr_erase = sfr_i.we && sfr_i.addr == `SFR_ERASE_COMMAND;
  assign wr_pg    = sfr_i.we && sfr_i.addr == `SFR_ERASE_PAGE_ADDRESS;
  assign idle     = state == flash_ctl_pkg::st_idle;

  // ==========================================================
  // next-state logic
  always_comb begin
    next_pwe      = pwe;
    next_meen     = meen;
    next_secure   = secure;
    next_pgadr    = pgadr;
    next_pg_fresh = pg_fresh;
    next_state    = state;
    next_cnt      = cnt;
    next_pe       = 1'b0;
    next_me       = 1'b0;
    next_fwr      = '0;
    next_xwr      = '0;
    if (wr_ctrl) begin
      if (!irq_enabled_i) begin
        next_pwe = sfr_i.wdata[`CTRL_PWE_BIT];
      end
      next_meen = sfr_i.wdata[`CTRL_MEEN_BIT];
      if (sfr_i.wdata[`CTRL_SECURE_BIT]) begin
        next_secure = 1'b1;
      end
    end
    if (wr_pg) begin
      next_pgadr    = sfr_i.wdata;
      next_pg_fresh = 1'b1;
    end
    unique case (state)
      flash_ctl_pkg::st_idle: begin
        if (wr_erase && sfr_i.wdata == `ERASE_PATTERN_MASS && meen && ice_s2) begin
          next_state = flash_ctl_pkg::st_mass;
          next_cnt   = `ERASE_MASS_TIME;
          next_me    = 1'b1;
          next_meen  = 1'b0;
        end else if (wr_erase && sfr_i.wdata == `ERASE_PATTERN_PAGE && pg_fresh) begin
          next_state    = flash_ctl_pkg::st_page;
          next_cnt      = `ERASE_PAGE_TIME;
          next_pe       = 1'b1;
          next_pg_fresh = 1'b0;
        end else if (store_dptr_i && pwe) begin
          next_state    = flash_ctl_pkg::st_write;
          next_cnt      = `WRITE_BYTE_TIME;
          next_fwr      = '{valid: 1'b1, addr: store_addr_i, data: store_acc_i};
          next_pwe      = 1'b0;
        end
        // any other pattern falls through with no effect
      end
      default: begin
        // erase writes are dropped until the running operation ends
        next_cnt = cnt - 16'h0001;
        if (cnt == 16'h0001) begin
          next_state = flash_ctl_pkg::st_idle;
        end
      end
    endcase
    next_bsy = next_state != flash_ctl_pkg::st_idle;
    if ((store_dptr_i && !pwe) || store_ri_i) begin
      next_xwr = '{valid: 1'b1, addr: store_addr_i, data: store_acc_i};
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (sfr_i.re && sfr_i.addr == `SFR_FLASH_CONTROL) begin
      next_rdata[`CTRL_PWE_BIT]     = pwe;
      next_rdata[`CTRL_MEEN_BIT]    = 1'b0; // write-only
      next_rdata[`CTRL_SECURE_BIT]  = secure;
      next_rdata[`CTRL_PREBOOT_BIT] = pre_s2;
    end else if (sfr_i.re && sfr_i.addr == `SFR_ERASE_PAGE_ADDRESS) begin
      next_rdata = pgadr;
    end
    next_crd      = fetch_i || table_read_i;
    next_crd_addr = code_addr_i;
    // vector table placement; index 0 means reset
    next_vec = (vector_index_i == 3'h0) ? `RESET_VECTOR :
      `VECTOR_BASE + `VECTOR_SPACING * {13'h0000, vector_index_i - 3'h1};
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwe      <= 1'b0;
      meen     <= 1'b0;
      secure   <= 1'b0;
      pgadr    <= 8'h00;
      pg_fresh <= 1'b0;
      rdata    <= 8'h00;
      state    <= flash_ctl_pkg::st_idle;
      cnt      <= 16'h0000;
      fwr      <= '0;
      xwr      <= '0;
      pe       <= 1'b0;
      me       <= 1'b0;
      crd      <= 1'b0;
      crd_addr <= `RESET_VECTOR;
      vec      <= `RESET_VECTOR;
      bsy      <= 1'b0;
      pre_s1   <= 1'b0;
      pre_s2   <= 1'b0;
      ice_s1   <= 1'b0;
      ice_s2   <= 1'b0;
    end else begin
      pwe      <= next_pwe;
      meen     <= next_meen;
      secure   <= next_secure;
      pgadr    <= next_pgadr;
      pg_fresh <= next_pg_fresh;
      rdata    <= next_rdata;
      state    <= next_state;
      cnt      <= next_cnt;
      fwr      <= next_fwr;
      xwr      <= next_xwr;
      pe       <= next_pe;
      me       <= next_me;
      crd      <= next_crd;
      crd_addr <= next_crd_addr;
      vec      <= next_vec;
      bsy      <= next_bsy;
      pre_s1   <= preboot_i;
      pre_s2   <= pre_s1;
      ice_s1   <= ice_enabled_i;
      ice_s2   <= ice_s1;
    end
  end

  assign sfr_rdata_o      = rdata;
  assign flash_wr_o       = fwr;
  assign xram_wr_o        = xwr;
  assign page_erase_o     = pe;
  assign mass_erase_o     = me;
  assign erase_page_o     = pgadr[7:1];
  assign busy_o           = bsy;
  assign ext_read_block_o = secure;
  assign code_rd_o        = crd;
  assign code_rd_addr_o   = crd_addr;
  assign vector_addr_o    = vec;

  // ==========================================================
  // checks
  a_mass_needs_ice: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(mass_erase_o) |-> $past(ice_s2) && $past(meen))
    else $error("mass erase without debug port or enable");
  a_page_pattern: assert property (@(posedge clk_i) disable iff (!resetn_i)
    page_erase_o |-> $past(sfr_i.wdata) == `ERASE_PATTERN_PAGE && $past(wr_erase))
    else $error("page erase without page pattern");
  a_bad_pattern: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (wr_erase && sfr_i.wdata != `ERASE_PATTERN_PAGE && sfr_i.wdata != `ERASE_PATTERN_MASS)
    |=> !page_erase_o && !mass_erase_o)
    else $error("erase from unknown pattern");
  a_meen_once: assert property (@(posedge clk_i) disable iff (!resetn_i)
    mass_erase_o |-> !meen)
    else $error("mass enable still armed after start");
  a_pwe_clears: assert property (@(posedge clk_i) disable iff (!resetn_i)
    flash_wr_o.valid |-> !pwe)
    else $error("write enable kept after byte");
  a_pwe_locked: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (wr_ctrl && irq_enabled_i && !pwe) |=> !pwe)
    else $error("write enable set with interrupts on");
  a_secure_sticky: assert property (@(posedge clk_i) disable iff (!resetn_i)
    secure |=> secure)
    else $error("security bit cleared");
  a_busy_blocks: assert property (@(posedge clk_i) disable iff (!resetn_i)
    busy_o |=> !(page_erase_o || mass_erase_o))
    else $error("erase started while busy");
  a_store_route: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (store_dptr_i && !pwe) |=> xram_wr_o.valid && !flash_wr_o.valid)
    else $error("store not sent to data ram");
  a_pwe_flash: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (store_dptr_i && pwe && idle) |=> flash_wr_o.valid && !xram_wr_o.valid)
    else $error("armed store not sent to flash");
  a_page_rearm: assert property (@(posedge clk_i) disable iff (!resetn_i)
    page_erase_o |-> !pg_fresh)
    else $error("page address reused for a second erase");
  a_meen_disarm: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (wr_erase && sfr_i.wdata == `ERASE_PATTERN_MASS && meen && ice_s2 && idle)
    |=> mass_erase_o && !meen)
    else $error("mass enable not consumed");
  a_secure_set: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (wr_ctrl && sfr_i.wdata[`CTRL_SECURE_BIT]) |=> ext_read_block_o)
    else $error("security bit write did not block reads");
  a_preboot_read: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (sfr_i.re && sfr_i.addr == `SFR_FLASH_CONTROL)
    |=> sfr_rdata_o[`CTRL_PREBOOT_BIT] == $past(pre_s2))
    else $error("preboot status not reported");
  a_code_read: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (fetch_i || table_read_i) |=> code_rd_o && code_rd_addr_o == $past(code_addr_i))
    else $error("code read not issued");
  a_reset_vector: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (vector_index_i == 3'h0) |=> vector_addr_o == `RESET_VECTOR)
    else $error("reset vector not at zero");
  a_page_busy: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (page_erase_o || mass_erase_o) |-> busy_o)
    else $error("erase pulse without busy");

  // ==========================================================
  // busy run length: no operation may hold busy beyond the mass erase time
  always_comb begin
    next_run_len = busy_o ? run_len + 6'h01 : 6'h00;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      run_len <= 6'h00;
    end else begin
      run_len <= next_run_len;
    end
  end

  a_busy_bound: assert property (@(posedge clk_i) disable iff (!resetn_i)
    {10'h000, run_len} <= `ERASE_MASS_TIME)
    else $error("busy held too long");
endmodule : flash_erase_write_control
`default_nettype wire

// [verif/cpu_core_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========
// core side: sfr requests and interrupt enable
module cpu_core_model (
  input  wire logic                   clk_i,
  input  wire logic [7:0]             rdata_i,
  output var  flash_ctl_pkg::sfr_req_s sfr_o,
  output var  logic                   irq_en_o
);
  logic [7:0] cpu_clock_divider;
  initial begin
    sfr_o = '0;
    irq_en_o = 1'b1;
    cpu_clock_divider = 8'h0c;
  end
  // a gap cycle follows every request, so back-to-back calls never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    sfr_o = '{1'b1, 1'b0, a, d};
    @(negedge clk_i);
    sfr_o = '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    sfr_o = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_i);
    sfr_o = '0;
    d = rdata_i;
  endtask : rd
  task automatic page_erase(input logic [7:0] p);
    wr(8'hb7, p);
    wr(8'h94, 8'h55);
  endtask : page_erase
  task automatic mass_erase();
    wr(8'hb2, 8'h02);
    wr(8'h94, 8'haa);
  endtask : mass_erase
  task automatic set_pwe();
    @(negedge clk_i);
    irq_en_o = 1'b0;
    wr(8'hb2, 8'h01);
  endtask : set_pwe
endmodule : cpu_core_model
`default_nettype wire

// [verif/flash_erase_write_control_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module flash_erase_write_control_tb;
  logic clk_i, resetn_i, ice, pre, sd, ri, fe, tr, irq, crd, pe, me, busy, blk;
  logic [15:0] sa, ca, cra, va;
  logic [7:0] acc, rdat, d;
  logic [6:0] pg;
  logic [2:0] vi;
  flash_ctl_pkg::sfr_req_s sfr;
  flash_ctl_pkg::mem_wr_s fw, xw;
  int bad_count, checks_done, n_page, n_mass, n_busy, cyc, p0, m0, b0;
  // ==========
  // instances
  cpu_core_model i_cpu_core_model (.clk_i(clk_i), .rdata_i(rdat), .sfr_o(sfr), .irq_en_o(irq));
  flash_erase_write_control i_flash_erase_write_control (
    .clk_i(clk_i), .resetn_i(resetn_i), .sfr_i(sfr), .sfr_rdata_o(rdat),
    .ice_enabled_i(ice), .preboot_i(pre), .irq_enabled_i(irq), .store_dptr_i(sd),
    .store_ri_i(ri), .store_addr_i(sa), .store_acc_i(acc), .fetch_i(fe),
    .table_read_i(tr), .code_addr_i(ca), .ext_read_i(1'b0), .vector_index_i(vi),
    .flash_wr_o(fw), .xram_wr_o(xw), .code_rd_o(crd), .code_rd_addr_o(cra),
    .page_erase_o(pe), .mass_erase_o(me), .erase_page_o(pg), .busy_o(busy),
    .ext_read_block_o(blk), .vector_addr_o(va));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ==========
  // pulse counters and hang guard
  always @(posedge clk_i) begin
    n_page <= n_page + int'(pe);
    n_mass <= n_mass + int'(me);
    n_busy <= n_busy + int'(busy);
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    i_cpu_core_model.wr(a, v);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    i_cpu_core_model.rd(a, d);
  endtask : rd
  task automatic store(input logic [15:0] a, input logic [7:0] v);
    @(negedge clk_i);
    sd = 1'b1;
    sa = a;
    acc = v;
    @(negedge clk_i);
    sd = 1'b0;
  endtask : store
  // ==========
  // scenarios
  task automatic t_reset();
    rd(8'hb7);
    chk(d, 8'h00);
    rd(8'hb2);
    chk(d, 8'h00);
  endtask : t_reset
  task automatic t_mass();
    i_cpu_core_model.mass_erase();
    chk(me, 1'b0);
    ice = 1'b1;
    idle(3);
    i_cpu_core_model.mass_erase();
    chk(me, 1'b1);
    idle(40);
    m0 = n_mass;
    wr(8'h94, 8'haa);
    idle(2);
    chk(n_mass - m0, 0);
  endtask : t_mass
  task automatic t_page();
    p0 = n_page;
    b0 = n_busy;
    m0 = n_mass;
    wr(8'hb7, 8'h0a);
    wr(8'h94, 8'h33);
    chk(busy, 1'b0);
    wr(8'h94, 8'h55);
    chk(pe, 1'b1);
    chk(pg, 7'h05);
    // mass attempt while the page erase still runs
    i_cpu_core_model.mass_erase();
    idle(30);
    chk(n_mass - m0, 0);
    chk(n_busy - b0, 16);
    wr(8'h94, 8'h55);
    idle(2);
    chk(n_page - p0, 1);
    rd(8'hb7);
    chk(d, 8'h0a);
  endtask : t_page
  task automatic t_write();
    wr(8'hb2, 8'h01);
    rd(8'hb2);
    chk(d[0], 1'b0);
    store(16'h1234, 8'h5a);
    chk(xw, {1'b1, 16'h1234, 8'h5a});
    i_cpu_core_model.set_pwe();
    store(16'h4321, 8'ha5);
    chk(fw, {1'b1, 16'h4321, 8'ha5});
    idle(6);
    rd(8'hb2);
    chk(d[0], 1'b0);
    store(16'h0055, 8'h3c);
    chk(xw.valid, 1'b1);
    @(negedge clk_i);
    ri = 1'b1;
    sa = 16'h0012;
    acc = 8'h77;
    @(negedge clk_i);
    ri = 1'b0;
    chk(xw, {1'b1, 16'h0012, 8'h77});
  endtask : t_write
  task automatic t_code();
    for (int k = 0; k < 2; k++) begin
      @(negedge clk_i);
      fe = (k == 0);
      tr = (k == 1);
      ca = 16'hff00 + 16'(k);
      @(negedge clk_i);
      fe = 1'b0;
      tr = 1'b0;
      chk(crd, 1'b1);
      chk(cra, 16'hff00 + 16'(k));
    end
    for (int k = 0; k < 8; k++) begin
      @(negedge clk_i);
      vi = 3'(k);
      @(negedge clk_i);
      chk(va, (k == 0) ? 16'h0000 : 16'(3 + 8 * (k - 1)));
    end
  endtask : t_code
  task automatic t_status();
    pre = 1'b1;
    idle(3);
    wr(8'hb2, 8'h40);
    wr(8'hb2, 8'h00);
    rd(8'hb2);
    chk(d[7], 1'b1);
    chk(d[6], 1'b1);
    chk(blk, 1'b1);
  endtask : t_status
  initial begin
    {resetn_i, ice, pre, sd, ri, fe, tr, sa, ca, acc, vi} = '0;
    {bad_count, checks_done, n_page, n_mass, n_busy, cyc} = '0;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    resetn_i = 1'b1;
    t_reset();
    t_mass();
    t_page();
    t_write();
    t_code();
    t_status();
    summarize();
  end
endmodule : flash_erase_write_control_tb
`default_nettype wire
